// file: pkg/eepsl_pkg.sv
package eepsl_pkg;

    // ==========================================
    // Geometry
    localparam int MEM_AW    = 14;
    localparam int PAGE_AW   = 6;
    localparam int MEM_SIZE  = 16384;
    localparam int PAGE_SIZE = 64;

    // ==========================================
    // Address byte and identification page
    localparam logic [3:0] DEV_TYPE_DEF = 4'h5; // Arbitrary value
    localparam logic [3:0] ID_TYPE_DEF  = 4'h6; // Arbitrary value
    localparam int         ID_SEL_BIT   = 2;    // Address bit 10 in high byte
    localparam int         LOCK_DBIT    = 1;

    // ==========================================
    // Timing
    localparam int T_WR_US   = 5000;
    localparam int CLK_MHZ   = 100;
    localparam int WR_CYCLES = T_WR_US * CLK_MHZ;
    localparam int WR_TW     = 20;

    // ==========================================
    // Pin vector layout
    localparam int PIN_A0  = 0;
    localparam int PIN_WP  = 3;
    localparam int PIN_SDA = 4;
    localparam int PIN_SCL = 5;
    localparam int PIN_N   = 6;
    localparam logic [PIN_N-1:0] PIN_RST = 6'h30;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_RX     = 3'h1,
        ST_RX_ACK = 3'h2,
        ST_TX     = 3'h3,
        ST_TX_ACK = 3'h4,
        ST_COMMIT = 3'h5
    } eepsl_st_t;

    typedef enum logic [1:0] {
        PH_DEV  = 2'h0,
        PH_AHI  = 2'h1,
        PH_ALO  = 2'h2,
        PH_DATA = 2'h3
    } eepsl_ph_t;

    typedef struct packed {
        logic [2:0]           en_s;
        logic                 en_ok;
        logic [PIN_N-1:0]     s1;
        logic [PIN_N-1:0]     s2;
        logic [PIN_N-1:0]     s3;
        logic [PIN_N-1:0]     pin;
        logic                 scl_p;
        logic                 sda_p;
        eepsl_st_t            st;
        eepsl_ph_t            ph;
        logic [3:0]           bitcnt;
        logic [7:0]           sh;
        logic                 rd;
        logic                 is_id;
        logic                 lock_sel;
        logic                 ack_ok;
        logic [MEM_AW-1:0]    addr;
        logic [PAGE_SIZE-1:0] mask;
        logic                 lock_pend;
        logic                 locked;
        logic [PAGE_AW:0]     widx;
        logic                 req;
        logic [2:0]           ack_s;
        logic                 sda_o;
        logic                 sda_oe;
        logic                 standby;
    } eepsl_lnk_t;

    typedef struct packed {
        logic [2:0]       req_s;
        logic             seen;
        logic             ack;
        logic             busy;
        logic [WR_TW-1:0] tmr;
    } eepsl_core_t;

endpackage

// file: src/eepsl_slave.sv
// Notes on behaviour
// - Write-protect high refuses all array writes
// - Three address pins, eight devices per bus
// - Data line only pulled low or released
// - Reset held: ignore bus, no writes
// - Reset release: machine idle, in standby
// - Reset reasserted: abandon activity, standby
// - After stop, standby once write finished
// - Data change during clock high is condition
// - Change on clock low, sample clock high
// - Start: data falls while clock high
// - Ignore bus until a start is seen
// - Stop: data rises while clock high
// - Array 16384 bytes, 64-byte pages
// - Extra lockable 64-byte identification page
// - Self-timed write cycle at most 5 ms
// - Partial page writes touch only received bytes
// - Address byte: type, pins, direction bit
// - Matching address acknowledged on ninth clock
// - Receiver acknowledges each byte by pulling low
// - Page write wraps low six address bits
module eepsl_slave
    import eepsl_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF,
    parameter logic [3:0] ID_TYPE  = ID_TYPE_DEF,
    parameter int         WR_CYC   = WR_CYCLES
) (
    // Clocks, reset, enable
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    input  wire logic link_clk,
    // Two-wire bus
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    // Straps
    input  wire logic hw_addr_bit0,
    input  wire logic hw_addr_bit1,
    input  wire logic hw_addr_bit2,
    input  wire logic wr_protect,
    // Status
    output logic      standby,
    output logic      wr_busy
);

    // ==========================================
    // Decoders
    function automatic logic dev_hit(input logic [7:0] b, input logic [3:0] t,
                                     input logic [2:0] a);
        return (b[7:4] == t) && (b[3:1] == a);
    endfunction

    // Synchroniser stages start at the idle bus level, no false edge after reset
    localparam eepsl_lnk_t LNK_RST = '{s1: PIN_RST, s2: PIN_RST, s3: PIN_RST, pin: PIN_RST,
                                       scl_p: 1'b1, sda_p: 1'b1,
                                       st: ST_IDLE, ph: PH_DEV, standby: 1'b1,
                                       default: '0};

    // ==========================================
    // Link domain reset
    logic [1:0] lrs;
    logic       lrst_n;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lrs <= 2'h0;
        end else begin
            lrs <= {lrs[0], 1'b1};
        end
    end
    assign lrst_n = lrs[1];

    // ==========================================
    // Storage
    logic [7:0] mem [MEM_SIZE];
    logic [7:0] idmem [PAGE_SIZE];
    logic [7:0] pbuf [PAGE_SIZE];

    eepsl_lnk_t  l;
    eepsl_lnk_t  next_l;
    eepsl_core_t c;
    eepsl_core_t next_c;

    logic       mem_we;
    logic       id_we;
    logic       pb_we;
    logic       scl;
    logic       sda;
    logic       start;
    logic       stop;
    logic       rise;
    logic       fall;
    logic       done;
    logic       hit_arr;
    logic       hit_id;
    logic       data_ok;
    logic [2:0] apin;
    logic [7:0] rdata;

    assign scl   = l.pin[PIN_SCL];
    assign sda   = l.pin[PIN_SDA];
    assign apin  = {l.pin[PIN_A0+2], l.pin[PIN_A0+1], l.pin[PIN_A0]};
    assign start = scl && l.scl_p && l.sda_p && !sda;
    assign stop  = scl && l.scl_p && !l.sda_p && sda;
    assign rise  = scl && !l.scl_p;
    assign fall  = !scl && l.scl_p;
    assign done  = (l.ack_s[1] == l.ack_s[2]) && (l.ack_s[2] == l.req);
    assign rdata = l.is_id ? idmem[l.addr[PAGE_AW-1:0]] : mem[l.addr];
    assign hit_arr = dev_hit(l.sh, DEV_TYPE, apin);
    assign hit_id  = dev_hit(l.sh, ID_TYPE, apin);

    // Identification page honours its lock, array honours write-protect
    assign data_ok = l.is_id ? (!l.locked && (!l.lock_sel || l.sh[LOCK_DBIT]))
                             : !l.pin[PIN_WP];

    // ==========================================
    // Link state machine
    always_comb begin
        next_l = l;
        mem_we = 1'b0;
        id_we  = 1'b0;
        pb_we  = 1'b0;
        next_l.en_s = {l.en_s[1:0], clk_en};
        if (l.en_s[1] == l.en_s[2]) begin
            next_l.en_ok = l.en_s[2];
        end
        if (l.en_ok) begin
            next_l.s1  = {scl_i, sda_i, wr_protect, hw_addr_bit2, hw_addr_bit1, hw_addr_bit0};
            next_l.s2  = l.s1;
            next_l.s3  = l.s2;
            next_l.pin = ((l.s2 ~^ l.s3) & l.s3) | ((l.s2 ^ l.s3) & l.pin);
            next_l.scl_p = scl;
            next_l.sda_p = sda;
            next_l.ack_s = {l.ack_s[1:0], c.ack};
            if (l.st == ST_COMMIT) begin
                next_l.sda_oe = 1'b0;
                if (!l.widx[PAGE_AW]) begin
                    mem_we = l.mask[l.widx[PAGE_AW-1:0]] && !l.is_id;
                    id_we  = l.mask[l.widx[PAGE_AW-1:0]] && l.is_id;
                    next_l.widx = l.widx + 7'h1;
                end else if (done) begin
                    next_l.st        = ST_IDLE;
                    next_l.mask      = '0;
                    next_l.locked    = l.locked || l.lock_pend;
                    next_l.lock_pend = 1'b0;
                end
            end else if (start) begin
                next_l.st        = ST_RX;
                next_l.ph        = PH_DEV;
                next_l.bitcnt    = 4'h0;
                next_l.sda_oe    = 1'b0;
                next_l.mask      = '0;
                next_l.lock_pend = 1'b0;
            end else if (stop) begin
                next_l.sda_oe = 1'b0;
                if ((|l.mask) || l.lock_pend) begin
                    next_l.st   = ST_COMMIT;
                    next_l.widx = '0;
                    next_l.req  = !l.req;
                end else begin
                    next_l.st = ST_IDLE;
                end
            end else begin
                case (l.st)
                    ST_RX: begin
                        if (rise) begin
                            next_l.sh     = {l.sh[6:0], sda};
                            next_l.bitcnt = l.bitcnt + 4'h1;
                        end else if (fall && l.bitcnt == 4'h8) begin
                            next_l.st = ST_IDLE;
                            case (l.ph)
                                PH_DEV: begin
                                    if (hit_arr || hit_id) begin
                                        next_l.st     = ST_RX_ACK;
                                        next_l.sda_oe = 1'b1;
                                        next_l.is_id  = hit_id;
                                        next_l.rd     = l.sh[0];
                                        next_l.ph     = PH_AHI;
                                    end
                                end
                                PH_AHI: begin
                                    next_l.st       = ST_RX_ACK;
                                    next_l.sda_oe   = 1'b1;
                                    next_l.addr     = {l.sh[MEM_AW-9:0], l.addr[7:0]};
                                    next_l.lock_sel = l.sh[ID_SEL_BIT];
                                    next_l.ph       = PH_ALO;
                                end
                                PH_ALO: begin
                                    next_l.st     = ST_RX_ACK;
                                    next_l.sda_oe = 1'b1;
                                    next_l.addr   = {l.addr[MEM_AW-1:8], l.sh};
                                    next_l.ph     = PH_DATA;
                                end
                                default: begin
                                    if (data_ok) begin
                                        next_l.st     = ST_RX_ACK;
                                        next_l.sda_oe = 1'b1;
                                        if (l.is_id && l.lock_sel) begin
                                            next_l.lock_pend = 1'b1;
                                        end else begin
                                            pb_we = 1'b1;
                                            next_l.mask[l.addr[PAGE_AW-1:0]] = 1'b1;
                                            next_l.addr[PAGE_AW-1:0] = l.addr[PAGE_AW-1:0] + 6'h1;
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                    ST_RX_ACK: begin
                        if (fall) begin
                            next_l.bitcnt = 4'h0;
                            if (l.rd) begin
                                next_l.st     = ST_TX;
                                next_l.sh     = rdata;
                                next_l.sda_oe = !rdata[7];
                            end else begin
                                next_l.st     = ST_RX;
                                next_l.sda_oe = 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        if (fall) begin
                            if (l.bitcnt == 4'h7) begin
                                next_l.st     = ST_TX_ACK;
                                next_l.sda_oe = 1'b0;
                                next_l.addr   = l.addr + 14'h1;
                            end else begin
                                next_l.sh     = {l.sh[6:0], 1'b0};
                                next_l.sda_oe = !l.sh[6];
                                next_l.bitcnt = l.bitcnt + 4'h1;
                            end
                        end
                    end
                    ST_TX_ACK: begin
                        if (rise) begin
                            next_l.ack_ok = !sda;
                        end else if (fall) begin
                            next_l.bitcnt = 4'h0;
                            if (l.ack_ok) begin
                                next_l.st     = ST_TX;
                                next_l.sh     = rdata;
                                next_l.sda_oe = !rdata[7];
                            end else begin
                                next_l.st = ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        next_l.sda_oe = 1'b0;
                    end
                endcase
            end
            next_l.standby = (next_l.st == ST_IDLE);
        end
        next_l.sda_o = 1'b0;
    end

    // Reset forces standby and drops any frame in flight
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            l <= LNK_RST;
        end else begin
            l <= next_l;
        end
    end

    always_ff @(posedge link_clk) begin
        if (pb_we) begin
            pbuf[l.addr[PAGE_AW-1:0]] <= l.sh;
        end
        if (mem_we) begin
            mem[{l.addr[MEM_AW-1:PAGE_AW], l.widx[PAGE_AW-1:0]}] <= pbuf[l.widx[PAGE_AW-1:0]];
        end
        if (id_we) begin
            idmem[l.widx[PAGE_AW-1:0]] <= pbuf[l.widx[PAGE_AW-1:0]];
        end
    end

    // ==========================================
    // Write cycle timer
    always_comb begin
        next_c = c;
        if (clk_en) begin
            next_c.req_s = {c.req_s[1:0], l.req};
            if (c.req_s[1] == c.req_s[2] && c.req_s[2] != c.seen) begin
                next_c.seen = c.req_s[2];
                next_c.busy = 1'b1;
                next_c.tmr  = '0;
            end else if (c.busy) begin
                if (c.tmr == WR_TW'(WR_CYC - 1)) begin
                    next_c.busy = 1'b0;
                    next_c.ack  = c.seen;
                end else begin
                    next_c.tmr = c.tmr + 20'h1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            c <= '0;
        end else begin
            c <= next_c;
        end
    end

    assign sda_o   = l.sda_o;
    assign sda_oe  = l.sda_oe;
    assign standby = l.standby;
    assign wr_busy = c.busy;

    // ==========================================
    // Checks
    chk_open_drain: assert property (@(posedge link_clk) disable iff (!lrst_n)
        l.sda_oe |-> !l.sda_o) else $error("data line driven high");
    chk_idle_quiet: assert property (@(posedge link_clk) disable iff (!lrst_n)
        l.st == ST_IDLE && $past(l.st) == ST_IDLE |-> !l.sda_oe) else $error("drive while idle");
    chk_start_seen: assert property (@(posedge link_clk) disable iff (!lrst_n)
        l.en_ok && start && l.st != ST_COMMIT |=> l.st == ST_RX && l.bitcnt == 4'h0)
        else $error("start missed");
    chk_stop_idle: assert property (@(posedge link_clk) disable iff (!lrst_n)
        l.en_ok && stop && l.st != ST_COMMIT && !(|l.mask) && !l.lock_pend |=> l.standby)
        else $error("stop without standby");
    chk_commit_hold: assert property (@(posedge link_clk) disable iff (!lrst_n)
        l.st == ST_COMMIT && !done |=> l.st == ST_COMMIT && !l.standby)
        else $error("standby before write done");
    chk_wp_refuse: assert property (@(posedge link_clk) disable iff (!lrst_n)
        l.en_ok && l.st == ST_RX && l.ph == PH_DATA && !l.is_id && l.pin[PIN_WP] && fall
        && l.bitcnt == 4'h8 && !start && !stop |=> !l.sda_oe && $stable(l.mask))
        else $error("write accepted under protect");
    chk_page_wrap: assert property (@(posedge link_clk) disable iff (!lrst_n)
        pb_we |=> l.addr[MEM_AW-1:PAGE_AW] == $past(l.addr[MEM_AW-1:PAGE_AW])
        && l.addr[PAGE_AW-1:0] == $past(l.addr[PAGE_AW-1:0]) + 6'h1)
        else $error("page address wrong");
    chk_addr_ack: assert property (@(posedge link_clk) disable iff (!lrst_n)
        l.en_ok && l.st == ST_RX && l.ph == PH_DEV && fall && l.bitcnt == 4'h8 && hit_arr
        && !start && !stop |=> l.sda_oe ##1 l.sda_oe) else $error("address not acked");
    chk_wr_bound: assert property (@(posedge mclk) disable iff (!arst_n)
        c.busy |-> c.tmr < WR_TW'(WR_CYC)) else $error("write cycle overrun");
    chk_reset_idle: assert property (@(posedge link_clk)
        !lrst_n |=> l.st == ST_IDLE || !lrst_n) else $error("not idle after reset");

    cov_read_byte: cover property (@(posedge link_clk) disable iff (!lrst_n)
        l.st == ST_TX_ACK && l.rd);
    cov_commit: cover property (@(posedge link_clk) disable iff (!lrst_n)
        l.st == ST_COMMIT ##1 l.st == ST_IDLE);
    cov_busy: cover property (@(posedge mclk) disable iff (!arst_n) $fell(c.busy));
    cov_wrap: cover property (@(posedge link_clk) disable iff (!lrst_n)
        pb_we && l.addr[PAGE_AW-1:0] == 6'h3f);

endmodule // eepsl_slave

// file: test/eepsl_bus_master.sv
module eepsl_bus_master #(
    parameter int Q = 64
) (
    // Clock and resolved data line
    input  wire logic mclk,
    input  wire logic sda,
    // Driven lines
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // ==========================================
    // Bus steps, each change just after mclk falls
    task automatic wait_q(input int n);
        repeat (n * Q) @(negedge mclk);
    endtask

    task automatic clock_bit(input logic b, output logic s);
        wait_q(1);
        sda_low = ~b;
        wait_q(1);
        scl = 1'b1;
        wait_q(1);
        s = sda;
        wait_q(1);
        scl = 1'b0;
    endtask

    task automatic start();
        wait_q(1);
        sda_low = 1'b0;
        wait_q(1);
        scl = 1'b1;
        wait_q(2);
        sda_low = 1'b1;
        wait_q(2);
        scl = 1'b0;
    endtask

    task automatic stop();
        wait_q(1);
        sda_low = 1'b1;
        wait_q(1);
        scl = 1'b1;
        wait_q(2);
        sda_low = 1'b0;
        wait_q(2);
    endtask

    // Clock goes low with data released, no start
    task automatic clock_low();
        wait_q(1);
        scl = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], s);
        end
        clock_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic get_byte(input logic ack_it, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(~ack_it, s);
    endtask
endmodule // eepsl_bus_master

// file: test/tb.sv
module tb
    import eepsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int         WR_N  = 3000;
    localparam logic [2:0] STRAP = 3'h5;

    logic mclk;
    logic link_clk;
    logic arst_n;
    logic wr_protect;
    logic scl;
    logic m_low;
    logic sda_o;
    logic sda_oe;
    logic standby;
    logic wr_busy;
    logic ok;
    int   busy_len;
    int   busy0;
    int   bad_count;
    int   checks_done;
    wire  sda = ~((sda_oe & ~sda_o) | m_low);

    // ==========================================
    // Clocks and instances
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #80 link_clk = ~link_clk;
    end
    always @(posedge mclk) if (wr_busy === 1'b1) busy_len <= busy_len + 1;

    eepsl_slave #(.WR_CYC(WR_N)) dut_u (
        .mclk(mclk), .arst_n(arst_n), .clk_en(1'b1), .link_clk(link_clk),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .hw_addr_bit0(STRAP[0]), .hw_addr_bit1(STRAP[1]), .hw_addr_bit2(STRAP[2]),
        .wr_protect(wr_protect), .standby(standby), .wr_busy(wr_busy)
    );
    eepsl_bus_master bm_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(m_low));

    // ==========================================
    // Compare, report and helper tasks
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] dev(input logic [2:0] pins, input logic rd);
        return {DEV_TYPE_DEF, pins, rd};
    endfunction

    task automatic link_wait(input int n);
        repeat (n) @(posedge link_clk);
        @(negedge mclk);
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 8000 && standby !== 1'b1; n++) @(negedge mclk);
    endtask

    // Start, address byte, two pointer bytes; all must be acknowledged
    task automatic hdr(input logic [13:0] a);
        logic k0, k1, k2;
        bm_u.start();
        bm_u.put_byte(dev(STRAP, 1'b0), k0);
        bm_u.put_byte({2'h0, a[13:8]}, k1);
        bm_u.put_byte(a[7:0], k2);
        chk_bit(k0 & k1 & k2, 1'b1);
    endtask

    task automatic read_at(input logic [13:0] a, input int n, input logic [7:0] e0, input logic [7:0] e1);
        logic       k;
        logic [7:0] d;
        hdr(a);
        bm_u.start();
        bm_u.put_byte(dev(STRAP, 1'b1), k);
        chk_bit(k, 1'b1);
        for (int i = 0; i < n; i++) begin
            bm_u.get_byte(i < n - 1, d);
            chk_byte(d, (i == 0) ? e0 : e1);
        end
        bm_u.stop();
    endtask

    // ==========================================
    // Watchdog and main sequence
    initial begin
        repeat (98000) @(posedge mclk);
        bad_count++;
        summarize();
    end

    initial begin
        arst_n      = 1'b0;
        wr_protect  = 1'b0;
        bad_count   = 0;
        checks_done = 0;
        bm_u.start();
        bm_u.put_byte(dev(STRAP, 1'b0), ok);
        chk_bit(ok, 1'b0);
        bm_u.stop();
        chk_bit(standby, 1'b1);
        chk_bit(wr_busy, 1'b0);
        link_wait(20);
        arst_n = 1'b1;
        link_wait(16);
        chk_bit(standby, 1'b1);
        bm_u.clock_low();
        bm_u.put_byte(dev(STRAP, 1'b0), ok);
        chk_bit(ok, 1'b0);
        bm_u.stop();
        bm_u.start();
        bm_u.put_byte(dev(3'h4, 1'b0), ok);
        chk_bit(ok, 1'b0);
        bm_u.stop();
        // Page-end write wraps to page start
        hdr(14'h013e);
        bm_u.put_byte(8'ha5, ok);
        chk_bit(ok, 1'b1);
        bm_u.put_byte(8'h5a, ok);
        chk_bit(ok, 1'b1);
        bm_u.put_byte(8'h3c, ok);
        chk_bit(ok, 1'b1);
        busy0 = busy_len;
        bm_u.stop();
        repeat (20) @(negedge mclk);
        chk_bit(wr_busy, 1'b1);
        chk_bit(standby, 1'b0);
        bm_u.start();
        bm_u.put_byte(dev(STRAP, 1'b0), ok);
        chk_bit(ok, 1'b0);
        bm_u.stop();
        wait_idle();
        chk_bit(standby, 1'b1);
        chk_bit(busy_len - busy0 >= WR_N - 1 && busy_len - busy0 <= WR_N + 2, 1'b1);
        read_at(14'h0100, 1, 8'h3c, 8'h00);
        read_at(14'h013e, 2, 8'ha5, 8'h5a);
        // Protected write is refused
        wr_protect = 1'b1;
        hdr(14'h0100);
        bm_u.put_byte(8'h77, ok);
        chk_bit(ok, 1'b0);
        bm_u.stop();
        wait_idle();
        wr_protect = 1'b0;
        read_at(14'h0100, 1, 8'h3c, 8'h00);
        // Lock command with data bit 1 clear is refused
        bm_u.start();
        bm_u.put_byte({ID_TYPE_DEF, STRAP, 1'b0}, ok);
        chk_bit(ok, 1'b1);
        bm_u.put_byte(8'h04, ok);
        chk_bit(ok, 1'b1);
        bm_u.put_byte(8'h00, ok);
        chk_bit(ok, 1'b1);
        bm_u.put_byte(8'h00, ok);
        chk_bit(ok, 1'b0);
        bm_u.stop();
        // Reset while the acknowledge still stands
        bm_u.start();
        bm_u.put_byte(dev(STRAP, 1'b0), ok);
        chk_bit(ok, 1'b1);
        arst_n = 1'b0;
        repeat (2) @(negedge mclk);
        chk_bit(sda_oe, 1'b0);
        chk_bit(sda_o, 1'b0);
        chk_bit(standby, 1'b1);
        link_wait(20);
        arst_n = 1'b1;
        bm_u.stop();
        link_wait(16);
        chk_bit(standby, 1'b1);
        summarize();
    end
endmodule // tb
